// >>> design/teg_event_mode.sv
// Event generation and channel mode logic for two timer channels
`timescale 1ns/1ps
`default_nettype none
`include "teg_defines.svh"
module teg_event_mode import teg_pkg::*; #(
   parameter int FAST_DLY = `TEG_FAST_DLY
) (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        reset_n,
   // Avalon-MM slave
   input  wire logic [7:0]  address,
   input  wire logic        read,
   input  wire logic        write,
   input  wire logic [31:0] writedata,
   input  wire logic [3:0]  byteenable,
   output logic      [31:0] readdata,
   output logic             waitrequest,
   // Timer core state
   input  wire teg_timer_t  timerIn,
   input  wire logic        updateEventIn,
   input  wire logic        triggerIn,
   input  wire logic        externalClearIn,
   // Forced events
   output logic             breakEvent,
   output logic             triggerEvent,
   output logic             controlUpdate,
   output logic             updateForce,
   output logic      [15:0] counterLoadValue,
   output logic      [1:0]  channelCapture,
   // Channel state
   output logic             mainOutputOn,
   output logic      [5:0]  statusFlags,
   output logic [1:0][15:0] compareValue,
   output teg_src_t         chSource [2],
   output logic      [1:0]  refOut,
   output logic      [1:0]  mainOut,
   output logic      [1:0]  compOut
);
   if (FAST_DLY < 2) begin : g_chk
      $error("FAST_DLY must be at least 2");
   end

   // ****************************************
   // Functions
   // ****************************************
   function automatic logic [15:0] merge(input logic [15:0] old,
                                         input logic [31:0] d,
                                         input logic [3:0]  be);
      merge = {be[1] ? d[15:8] : old[15:8], be[0] ? d[7:0] : old[7:0]};
   endfunction

   function automatic logic pwm(input teg_omode_t m, input logic down,
                                input logic [15:0] c, input logic [15:0] r);
      logic lvl;
      lvl = down ? !(c > r) : (c < r);
      pwm = (m == OM_PWM2) ? ~lvl : lvl;
   endfunction

   function automatic teg_src_t srcDecode(input int ch, input logic [1:0] s);
      unique case (s)
         2'h0: srcDecode = SRC_OUTPUT;
         2'h1: srcDecode = SRC_TI1;
         2'h2: srcDecode = (ch == 0) ? SRC_TI2 : SRC_TI0;
         2'h3: srcDecode = SRC_COMBINED;
      endcase
   endfunction

   // ****************************************
   // Bus slave
   // ****************************************
   logic        ack;
   logic        wrStb;
   logic [31:0] rdVal;
   logic [7:0]  evPulse;
   logic [15:0] shadow [2];
   logic [15:0] active [2];
   teg_chcfg_t  cfg [2];
   logic [5:0]  next_flags;

   assign waitrequest = (read | write) & ~ack;
   assign wrStb       = write & ack;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ack <= 1'b0;
      end else begin
         ack <= (read | write) & ~ack;
      end
   end

   always_comb begin
      unique case (address)
         `TEG_ADDR_EVENT: rdVal = 32'h0000_0000;
         `TEG_ADDR_MODE:  rdVal = {16'h0000, cfg[1], cfg[0]};
         `TEG_ADDR_CMP0:  rdVal = {16'h0000, cfg[0].preloadOn ? shadow[0] : active[0]};
         `TEG_ADDR_CMP1:  rdVal = {16'h0000, cfg[1].preloadOn ? shadow[1] : active[1]};
         `TEG_ADDR_STAT:  rdVal = {26'h0000000, statusFlags};
         `TEG_ADDR_CTRL:  rdVal = {31'h00000000, mainOutputOn};
         default:         rdVal = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         readdata <= 32'h0000_0000;
      end else if (read & ~ack) begin
         readdata <= rdVal;
      end
   end

   // ****************************************
   // Event register
   // ****************************************
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         evPulse <= 8'h00;
      end else if (wrStb && address == `TEG_ADDR_EVENT && byteenable[0]) begin
         evPulse <= writedata[7:0];
      end else begin
         evPulse <= 8'h00;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         counterLoadValue <= 16'h0000;
      end else if (wrStb && address == `TEG_ADDR_EVENT && byteenable[0]
                   && writedata[`TEG_EV_UPD]) begin
         // Down counting reloads, center or up clears
         counterLoadValue <= (timerIn.countDown && !timerIn.centerAligned)
                             ? timerIn.autoReload : 16'h0000;
      end
   end

   assign breakEvent    = evPulse[`TEG_EV_BRK];
   assign triggerEvent  = evPulse[`TEG_EV_TRG];
   assign controlUpdate = evPulse[`TEG_EV_COM] & timerIn.controlPreloadOn;
   assign updateForce   = evPulse[`TEG_EV_UPD];

   // ****************************************
   // Status flags and main output
   // ****************************************
   always_comb begin
      next_flags = statusFlags;
      if (wrStb && address == `TEG_ADDR_STAT && byteenable[0]) begin
         next_flags = statusFlags & writedata[5:0];
      end
      if (evPulse[`TEG_EV_TRG]) begin
         next_flags[`TEG_ST_TRG] = 1'b1;
      end
      if (evPulse[`TEG_EV_BRK]) begin
         next_flags[`TEG_ST_BRK] = 1'b1;
      end
      for (int i = 0; i < 2; i++) begin
         if (evPulse[`TEG_EV_CH0 + i]) begin
            if (cfg[i].select != 2'h0 && statusFlags[`TEG_ST_CH0 + i]) begin
               next_flags[`TEG_ST_OV0 + i] = 1'b1;
            end
            next_flags[`TEG_ST_CH0 + i] = 1'b1;
         end
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         statusFlags <= 6'h00;
      end else begin
         statusFlags <= next_flags;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         mainOutputOn <= 1'b0;
      end else if (evPulse[`TEG_EV_BRK]) begin
         mainOutputOn <= 1'b0;
      end else if (wrStb && address == `TEG_ADDR_CTRL && byteenable[0]) begin
         mainOutputOn <= writedata[0];
      end
   end

   // ****************************************
   // Mode register
   // ****************************************
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         for (int i = 0; i < 2; i++) begin
            cfg[i] <= 8'(`TEG_MODE_RESET >> (8 * i));
         end
      end else if (wrStb && address == `TEG_ADDR_MODE) begin
         for (int i = 0; i < 2; i++) begin
            if (byteenable[i]) begin
               cfg[i].clearOn <= writedata[8 * i + 7];
               cfg[i].fastOn  <= writedata[8 * i + 2];
               if (!timerIn.chEnable[i]) begin
                  cfg[i].select <= writedata[8 * i +: 2];
               end
               if (!(timerIn.lockLevel == `TEG_LOCK_FULL
                     && cfg[i].select == 2'h0)) begin
                  cfg[i].mode      <= teg_omode_t'(writedata[8 * i + 4 +: 3]);
                  cfg[i].preloadOn <= writedata[8 * i + 3];
               end
            end
         end
      end
   end

   always_comb begin
      for (int i = 0; i < 2; i++) begin
         chSource[i] = srcDecode(i, cfg[i].select);
      end
   end

   // ****************************************
   // Compare and capture registers
   // ****************************************
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         for (int i = 0; i < 2; i++) begin
            shadow[i] <= 16'h0000;
            active[i] <= 16'h0000;
         end
      end else begin
         for (int i = 0; i < 2; i++) begin
            if (wrStb && address == ((i == 0) ? `TEG_ADDR_CMP0 : `TEG_ADDR_CMP1)) begin
               shadow[i] <= merge(shadow[i], writedata, byteenable);
               if (!cfg[i].preloadOn) begin
                  active[i] <= merge(active[i], writedata, byteenable);
               end
            end
            if ((updateEventIn || evPulse[`TEG_EV_UPD]) && cfg[i].preloadOn) begin
               active[i] <= shadow[i];
            end
            if (evPulse[`TEG_EV_CH0 + i] && cfg[i].select != 2'h0) begin
               active[i] <= timerIn.counter;
               shadow[i] <= timerIn.counter;
            end
         end
      end
   end

   always_comb begin
      for (int i = 0; i < 2; i++) begin
         compareValue[i]   = active[i];
         channelCapture[i] = evPulse[`TEG_EV_CH0 + i] & (cfg[i].select != 2'h0);
      end
   end

   // ****************************************
   // Output reference
   // ****************************************
   logic [FAST_DLY-2:0] trigPipe;
   logic [1:0]          matchQ;
   logic [1:0]          pwmQ;
   logic [1:0]          refQ;
   logic [1:0]          match;
   logic [1:0]          pwmLvl;
   logic [1:0]          fastLvl;
   logic [1:0]          clr;
   teg_omode_t          modeQ [2];

   always_comb begin
      for (int i = 0; i < 2; i++) begin
         match[i]   = timerIn.counter == active[i];
         pwmLvl[i]  = pwm(cfg[i].mode, timerIn.countDown, timerIn.counter, active[i]);
         fastLvl[i] = pwm(cfg[i].mode, timerIn.countDown, active[i], active[i]);
         clr[i]     = cfg[i].clearOn & externalClearIn & (cfg[i].select == 2'h0);
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         trigPipe <= '0;
      end else begin
         trigPipe <= (FAST_DLY-1)'({trigPipe, triggerIn});
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         matchQ <= 2'h0;
         pwmQ   <= 2'h0;
         refQ   <= 2'h0;
         for (int i = 0; i < 2; i++) begin
            modeQ[i] <= OM_FROZEN;
         end
      end else begin
         matchQ <= match;
         pwmQ   <= pwmLvl;
         for (int i = 0; i < 2; i++) begin
            modeQ[i] <= cfg[i].mode;
            // Input channels leave the reference alone
            if (cfg[i].select == 2'h0) begin
               if (clr[i]) begin
                  refQ[i] <= 1'b0;
               end else begin
                  unique case (cfg[i].mode)
                     OM_FROZEN: refQ[i] <= refQ[i];
                     OM_SET: begin
                        if (match[i] && !matchQ[i]) refQ[i] <= 1'b1;
                     end
                     OM_CLEAR: begin
                        if (match[i] && !matchQ[i]) refQ[i] <= 1'b0;
                     end
                     OM_TOGGLE: begin
                        if (match[i] && !matchQ[i]) refQ[i] <= ~refQ[i];
                     end
                     OM_FORCE_LOW:  refQ[i] <= 1'b0;
                     OM_FORCE_HIGH: refQ[i] <= 1'b1;
                     OM_PWM1, OM_PWM2: begin
                        if (cfg[i].fastOn && trigPipe[FAST_DLY-2]) begin
                           refQ[i] <= fastLvl[i];
                        end else if (pwmLvl[i] != pwmQ[i] || modeQ[i] == OM_FROZEN) begin
                           refQ[i] <= pwmLvl[i];
                        end
                     end
                  endcase
               end
            end
         end
      end
   end

   assign refOut  = refQ & ~clr;
   assign mainOut = refOut ^ timerIn.chPolarity;
   assign compOut = refOut ^ timerIn.chCompPolarity;

   // ****************************************
   // Assertions
   // ****************************************
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);

   AST_BREAK: assert property (breakEvent |=> !mainOutputOn && statusFlags[`TEG_ST_BRK])
      else $error("break did not clear main output or set flag");
   AST_SELFCLR: assert property (evPulse != 8'h00 |=> evPulse == 8'h00)
      else $error("event bit did not self-clear");
   AST_TRIG: assert property (triggerEvent |=> statusFlags[`TEG_ST_TRG])
      else $error("trigger force did not set flag");
   AST_COM: assert property (wrStb && address == `TEG_ADDR_EVENT && byteenable[0]
                             && writedata[`TEG_EV_COM]
                             |=> controlUpdate == timerIn.controlPreloadOn)
      else $error("control update force did not follow preload control");
   AST_RELOAD: assert property (wrStb && address == `TEG_ADDR_EVENT && byteenable[0]
                               && writedata[`TEG_EV_UPD] |=> updateForce
                               && counterLoadValue == (($past(timerIn.countDown)
                               && !$past(timerIn.centerAligned))
                               ? $past(timerIn.autoReload) : 16'h0000))
      else $error("forced update loaded wrong counter value");
   AST_OVCAP: assert property (channelCapture[1] && statusFlags[`TEG_ST_CH0 + 1]
                              |=> statusFlags[`TEG_ST_OV0 + 1])
      else $error("second capture did not set overcapture");
   AST_PRELOAD: assert property (updateEventIn && cfg[0].preloadOn
                                && !channelCapture[0] |=> active[0] == $past(shadow[0]))
      else $error("update event did not copy shadow compare");
   AST_CAPT: assert property (channelCapture[0] |=> active[0] == $past(timerIn.counter))
      else $error("capture did not take counter");
   AST_SEL: assert property (wrStb && address == `TEG_ADDR_MODE && byteenable[0]
                             && timerIn.chEnable[0] |=> $stable(cfg[0].select))
      else $error("select changed while channel enabled");
   AST_CLEAR: assert property (clr[0] |-> !refOut[0] ##1 !refQ[0])
      else $error("reference not cleared by external clear");
   AST_FLOW: assert property ($past(cfg[0].mode) == OM_FORCE_LOW
                             && $past(cfg[0].select) == 2'h0 |-> refQ[0] == 1'b0)
      else $error("force low mode left reference high");
   AST_EVREAD: assert property (read && !ack && address == `TEG_ADDR_EVENT
                               |=> readdata == 32'h0000_0000)
      else $error("event register read not zero");

   COV_BREAK: cover property (breakEvent);
   COV_CAPT: cover property (channelCapture[0] ##1 channelCapture[0] == 1'b0);
   COV_PWM: cover property (cfg[0].mode == OM_PWM1 && $rose(refQ[0]));
   COV_OVCAP: cover property (channelCapture[1] && statusFlags[`TEG_ST_CH0 + 1]);
   COV_FAST: cover property (trigPipe[FAST_DLY-2] && cfg[0].fastOn && cfg[0].mode == OM_PWM1);
endmodule
`default_nettype wire

// >>> design/teg_defines.svh
// Offsets, field positions, reset values and timing counts of the event/mode block
`ifndef TEG_DEFINES_SVH
`define TEG_DEFINES_SVH
// ****************************************
// Register map
// ****************************************
`define TEG_ADDR_EVENT 8'h14
`define TEG_ADDR_MODE  8'h18
`define TEG_ADDR_CMP0  8'h34
`define TEG_ADDR_CMP1  8'h38
`define TEG_ADDR_STAT  8'h40
`define TEG_ADDR_CTRL  8'h44
`define TEG_MODE_RESET 16'h0000
// ****************************************
// Event bits, status bits and lock level
// ****************************************
`define TEG_EV_UPD 0
`define TEG_EV_CH0 1
`define TEG_EV_COM 5
`define TEG_EV_TRG 6
`define TEG_EV_BRK 7
`define TEG_ST_CH0 0
`define TEG_ST_TRG 2
`define TEG_ST_BRK 3
`define TEG_ST_OV0 4
`define TEG_LOCK_FULL 2'h3
// ****************************************
// Timing
// ****************************************
`define TEG_FAST_DLY 3
`define TEG_SLOW_DLY 5
`endif

// >>> design/teg_pkg.sv
// Types of the event/mode block
package teg_pkg;
   typedef enum logic [2:0] {
      OM_FROZEN, OM_SET, OM_CLEAR, OM_TOGGLE,
      OM_FORCE_LOW, OM_FORCE_HIGH, OM_PWM1, OM_PWM2
   } teg_omode_t;
   typedef enum logic [2:0] {
      SRC_OUTPUT, SRC_TI0, SRC_TI1, SRC_TI2, SRC_COMBINED
   } teg_src_t;
   typedef struct packed {
      logic       clearOn;
      teg_omode_t mode;
      logic       preloadOn;
      logic       fastOn;
      logic [1:0] select;
   } teg_chcfg_t;
   typedef struct packed {
      logic [15:0] counter;
      logic [15:0] autoReload;
      logic        countDown;
      logic        centerAligned;
      logic        controlPreloadOn;
      logic [1:0]  lockLevel;
      logic [1:0]  chEnable;
      logic [1:0]  chPolarity;
      logic [1:0]  chCompPolarity;
   } teg_timer_t;
endpackage

// >>> test/tb_teg_event_mode.sv
// Self-checking bench for the event and channel mode block
`timescale 1ns/1ps
`default_nettype none
`include "teg_defines.svh"
module tb_teg_event_mode import teg_pkg::*; ;
   // ****************************************
   // Signals
   // ****************************************
   logic             clk        = 1'b0;
   logic             reset_n    = 1'b0;
   logic [7:0]       address    = 8'h00;
   logic             read       = 1'b0;
   logic             write      = 1'b0;
   logic [31:0]      writedata  = 32'h0;
   logic [3:0]       byteenable = 4'hf;
   logic [31:0]      readdata;
   logic             waitrequest;
   teg_timer_t       tmr        = '0;
   logic             updEv      = 1'b0;
   logic             trig       = 1'b0;
   logic             extClr     = 1'b0;
   logic             brk, trgEv, ctlUpd, updF, main_output_on;
   logic [15:0]      loadVal, loadSeen;
   logic [1:0]       chCap, refSeen, mOut, cOut;
   logic [5:0]       flags;
   logic [1:0][15:0] cmpVal;
   teg_src_t         src [2];
   logic [3:0]       seenP      = 4'h0;
   logic [1:0]       seenCap    = 2'h0;
   logic [31:0]      seed       = 32'hf6e7a287;
   int               errors     = 0;
   int               cmpCount   = 0;
   logic             catchClr   = 1'b0;
   logic [7:0]       pm [8]     = '{8'h68, 8'h68, 8'h68, 8'h68, 8'h78, 8'h78, 8'h78, 8'h78};
   logic [7:0]       mm [5]     = '{8'h10, 8'h00, 8'h20, 8'h30, 8'h30};
   teg_src_t         s0 [4]     = '{SRC_OUTPUT, SRC_TI1, SRC_TI2, SRC_COMBINED};
   teg_src_t         s1 [4]     = '{SRC_OUTPUT, SRC_TI1, SRC_TI0, SRC_COMBINED};

   always #20 clk = ~clk;

   teg_event_mode #(.FAST_DLY(3)) teg_event_mode_i (
      .clk(clk), .reset_n(reset_n), .address(address), .read(read), .write(write),
      .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
      .waitrequest(waitrequest), .timerIn(tmr), .updateEventIn(updEv),
      .triggerIn(trig), .externalClearIn(extClr), .breakEvent(brk),
      .triggerEvent(trgEv), .controlUpdate(ctlUpd), .updateForce(updF),
      .counterLoadValue(loadVal), .channelCapture(chCap), .mainOutputOn(main_output_on),
      .statusFlags(flags), .compareValue(cmpVal), .chSource(src), .refOut(refSeen),
      .mainOut(mOut), .compOut(cOut));

   // Pulse catchers
   always @(posedge clk) begin
      if (catchClr) begin
         seenP   <= 4'h0;
         seenCap <= 2'h0;
      end else begin
         seenP   <= seenP | {ctlUpd === 1'b1, updF === 1'b1, trgEv === 1'b1, brk === 1'b1};
         seenCap <= seenCap | chCap;
      end
      if (updF === 1'b1) loadSeen <= loadVal;
   end

   // ****************************************
   // Helpers
   // ****************************************
   function automatic logic [31:0] xs(input logic [31:0] x);
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      x = x ^ (x << 5);
      return x;
   endfunction

   // Expected PWM level from mode, direction, counter and compare
   function automatic logic pwmExp(input logic m2, input logic down,
                                   input logic [15:0] cnt, input logic [15:0] cmp);
      return m2 ^ (down ? (cnt <= cmp) : (cnt < cmp));
   endfunction

   task automatic rnd16(output logic [15:0] v);
      seed = xs(seed);
      v = seed[15:0];
   endtask

   task automatic final_report();
      if (errors == 0 && cmpCount > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
      cmpCount++;
      if (seen !== exp) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", n, exp, seen);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask

   task automatic clr();
      catchClr <= 1'b1;
      @(posedge clk);
      catchClr <= 1'b0;
   endtask

   task automatic bus(input logic wr, input logic [7:0] a, input logic [15:0] d,
                      output logic [31:0] q);
      int n;
      @(posedge clk);
      address   <= a;
      writedata <= {16'h0, d};
      write     <= wr;
      read      <= !wr;
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (waitrequest !== 1'b0 && n < 20);
      if (n >= 20) begin
         errors++;
         final_report();
      end
      @(posedge clk);
      q = readdata;
      write <= 1'b0;
      read  <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
      tick(3);
   endtask

   task automatic chkRd(input string n, input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] q;
      bus(1'b0, a, 16'h0, q);
      check(n, q, exp);
   endtask

   task automatic match(input logic [15:0] c);
      tmr.counter <= c - 16'h1;
      tick(3);
      tmr.counter <= c;
      tick(3);
   endtask

   initial begin
      repeat (50000) @(posedge clk);
      errors++;
      final_report();
   end

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      logic [15:0] v, c;
      repeat (2) @(posedge clk);
      reset_n <= 1'b1;
      chkRd("mode reset", `TEG_ADDR_MODE, 32'h0);
      chkRd("event read", `TEG_ADDR_EVENT, 32'h0);
      chkRd("unmapped read", 8'h00, 32'h0);
      wr(`TEG_ADDR_CTRL, 16'h1);
      check("main output on", main_output_on, 1);
      clr();
      wr(`TEG_ADDR_EVENT, 16'h0080);
      check("break pulse", seenP[0], 1);
      check("main output off", main_output_on, 0);
      check("break flag", flags[`TEG_ST_BRK], 1);
      chkRd("event self clear", `TEG_ADDR_EVENT, 32'h0);
      wr(`TEG_ADDR_STAT, 16'h0);
      clr();
      wr(`TEG_ADDR_EVENT, 16'h0000);
      check("zero write", {seenCap, seenP, flags}, 0);
      wr(`TEG_ADDR_EVENT, 16'h0040);
      check("trigger flag", {seenP[1], flags}, 7'h44);
      tmr.controlPreloadOn <= 1'b0;
      clr();
      wr(`TEG_ADDR_EVENT, 16'h0020);
      check("control update off", seenP[3], 0);
      tmr.controlPreloadOn <= 1'b1;
      clr();
      wr(`TEG_ADDR_EVENT, 16'h0020);
      check("control update on", seenP[3], 1);
      for (int i = 0; i < 3; i++) begin
         rnd16(v);
         tmr.autoReload    <= v | 16'h1;
         tmr.countDown     <= (i != 0);
         tmr.centerAligned <= (i == 2);
         clr();
         wr(`TEG_ADDR_EVENT, 16'h0001);
         check("update pulse", seenP[2], 1);
         check("reload value", loadSeen, (i == 1) ? (v | 16'h1) : 16'h0);
      end
      tmr.countDown <= 1'b0;
      wr(`TEG_ADDR_STAT, 16'h0);
      clr();
      wr(`TEG_ADDR_EVENT, 16'h0002);
      check("output force flag", {seenCap, flags}, 8'h01);
      for (int s = 0; s < 4; s++) begin
         wr(`TEG_ADDR_MODE, 16'(s) << 8 | 16'(s));
         check("select ch0", src[0], s0[s]);
         check("select ch1", src[1], s1[s]);
      end
      tmr.chEnable <= 2'b01;
      wr(`TEG_ADDR_MODE, 16'h0101);
      chkRd("select locked", `TEG_ADDR_MODE, 32'h0103);
      check("select ch1 new", src[1], SRC_TI1);
      tmr.chEnable <= 2'b00;
      rnd16(v);
      tmr.counter <= v;
      wr(`TEG_ADDR_STAT, 16'h0);
      clr();
      wr(`TEG_ADDR_EVENT, 16'h0004);
      check("capture value", cmpVal[1], v);
      check("capture flags", {seenCap, flags}, 8'h82);
      wr(`TEG_ADDR_EVENT, 16'h0004);
      check("overcapture", flags, 6'h22);
      wr(`TEG_ADDR_MODE, 16'h0);
      rnd16(c);
      c = (c & 16'h7ff0) | 16'h0100;
      wr(`TEG_ADDR_CMP0, c);
      check("compare direct", cmpVal[0], c);
      tmr.chPolarity <= 2'b01;
      wr(`TEG_ADDR_MODE, 16'h0050);
      check("force high", {refSeen[0], mOut[0], cOut[0]}, 3'b101);
      extClr <= 1'b1;
      tick(3);
      check("clear ignored", refSeen[0], 1);
      wr(`TEG_ADDR_MODE, 16'h00d0);
      check("clear active", refSeen[0], 0);
      extClr <= 1'b0;
      wr(`TEG_ADDR_MODE, 16'h0040);
      check("force low", {refSeen[0], mOut[0], cOut[0]}, 3'b010);
      for (int i = 0; i < 5; i++) begin
         wr(`TEG_ADDR_MODE, {8'h00, mm[i]});
         match(c);
         check("match mode", refSeen[0], (i == 2 || i == 4) ? 0 : 1);
      end
      for (int i = 0; i < 8; i++) begin
         wr(`TEG_ADDR_MODE, 16'h0);
         v = (i[0] ^ i[1]) ? c - 16'd5 : c + 16'd3;
         tmr.countDown <= i[1];
         tmr.counter   <= v;
         wr(`TEG_ADDR_MODE, {8'h00, pm[i]});
         check("pwm level", refSeen[0], pwmExp(i[2], i[1], v, c));
      end
      tmr.countDown <= 1'b0;
      tmr.counter   <= c - 16'd5;
      for (int f = 0; f < 2; f++) begin
         wr(`TEG_ADDR_MODE, 16'h0);
         wr(`TEG_ADDR_MODE, f ? 16'h006c : 16'h0068);
         trig <= 1'b1;
         tick(1);
         trig <= 1'b0;
         tick(1);
         check("fast early", refSeen[0], 1);
         tick(4);
         check("fast trigger", refSeen[0], !f);
      end
      wr(`TEG_ADDR_MODE, 16'h0068);
      rnd16(v);
      wr(`TEG_ADDR_CMP0, v ^ c);
      check("shadow held", cmpVal[0], c);
      updEv <= 1'b1;
      tick(1);
      updEv <= 1'b0;
      tick(2);
      check("shadow copied", cmpVal[0], v ^ c);
      tmr.lockLevel <= `TEG_LOCK_FULL;
      wr(`TEG_ADDR_MODE, 16'h0040);
      chkRd("lock mode", `TEG_ADDR_MODE, 32'h0068);
      final_report();
   end
endmodule
`default_nettype wire
